//--- verilog/csf_pkg.sv
`default_nettype none
package csf_pkg;
  // Key that opens the protected-write window (value arbitrary).
  localparam logic [7:0]  IO_REGISTER_KEY  = 8'h5A;
  // Protected-write window length in CPU instructions.
  localparam logic [2:0]  CCP_WINDOW       = 3'h4;
  // Main clock source encodings.
  localparam logic [3:0]  SRC_INT_HF       = 4'h0;
  localparam logic [3:0]  SRC_INT_LOW      = 4'h1;
  localparam logic [3:0]  SRC_EXT_LOW      = 4'h2;
  localparam logic [3:0]  SRC_EXT_HF       = 4'h3;
  // Failure detector target encodings.
  localparam logic [1:0]  TGT_MAIN         = 2'h0;
  localparam logic [1:0]  TGT_EXT_HF       = 2'h1;
  localparam logic [1:0]  TGT_EXT_LOW      = 2'h2;
  // Start-up counts in oscillator cycles.
  localparam logic [12:0] SUT_EXT_CLOCK    = 13'h0002;
  localparam logic [12:0] SUT_XTAL_0       = 13'h0100;
  localparam logic [12:0] SUT_XTAL_1       = 13'h0400;
  localparam logic [12:0] SUT_XTAL_2       = 13'h0800;
  localparam logic [12:0] SUT_XTAL_3       = 13'h1000;
  // Failure detector counts in internal low-frequency ticks.
  localparam logic [3:0]  FAIL_TIMEOUT     = 4'h4;
  localparam logic [3:0]  FAIL_REPEAT      = 4'hA;
  // PLL lock time in core clock cycles.
  localparam logic [6:0]  PLL_LOCK_CYCLES  = 7'h40;
  // Reset values.
  localparam logic [7:0]  TRIM_RESET       = 8'h00;
  // Power states of the device.
  typedef enum logic [1:0] {
    CSF_ACTIVE, CSF_IDLE, CSF_STANDBY, CSF_POWERDOWN
  } csf_sleep_type;
endpackage
`default_nettype wire

//--- verilog/csf_startup.sv
`timescale 1ns/1ps
`default_nettype none
// Counts oscillator edges after a start request until stable.
module csf_startup (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       resetn,
  // Oscillator setup.
  input  wire logic       run,
  input  wire logic       ext_clock,
  input  wire logic [1:0] delay_sel,
  input  wire logic       osc_level,
  // Status.
  output logic            stable,
  output logic            osc_edge
);
  import csf_pkg::*;
  logic        prev;    // Previous oscillator level.
  logic [12:0] count;   // Edges counted since the start request.
  wire  [12:0] xtal_target;
  wire  [12:0] target;

  // Crystal start-up count from the field, or the fixed clock count.
  assign xtal_target = (delay_sel == 2'h0) ? SUT_XTAL_0 :
                       (delay_sel == 2'h1) ? SUT_XTAL_1 :
                       (delay_sel == 2'h2) ? SUT_XTAL_2 : SUT_XTAL_3;
  assign target   = ext_clock ? SUT_EXT_CLOCK : xtal_target;
  assign osc_edge = osc_level & ~prev;

  // Stable only once the configured number of edges has been seen.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prev   <= 1'b0;
      count  <= 13'h0000;
      stable <= 1'b0;
    end else begin
      prev <= osc_level;
      if (!run) begin
        count  <= 13'h0000;
        stable <= 1'b0;
      end else if (osc_edge && !stable) begin
        count  <= count + 13'h0001;
        stable <= (count + 13'h0001 == target);
      end
    end
  end

  chk_stable_count: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(stable) |-> count == target)
    else $error("Oscillator stable before its start-up count.");
endmodule
`default_nettype wire

//--- verilog/csf_fail_detect.sv
`timescale 1ns/1ps
`default_nettype none
// Edge watchdog with forced test and periodic repeat.
module csf_fail_detect (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic resetn,
  // Watch inputs.
  input  wire logic armed,
  input  wire logic src_edge,
  input  wire logic tick,
  input  wire logic force_fail,
  input  wire logic clear_req,
  // Condition outputs.
  output logic      fail_cond,
  output logic      fail_start,
  output logic      repeat_due
);
  import csf_pkg::*;
  logic [3:0] idle_cnt;  // Ticks since the last source edge.
  logic [3:0] rep_cnt;   // Ticks since the last interrupt issue.
  logic       force_d;   // Previous force level.
  wire        timeout;
  wire        set_fail;
  wire        clr_fail;

  assign timeout  = armed && tick && idle_cnt == FAIL_TIMEOUT - 4'h1;
  assign set_fail = force_fail || timeout;
  assign clr_fail = src_edge || clear_req || (force_d && !force_fail);

  // Idle counter restarts on each edge or when disarmed.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 4'h0;
    end else if (src_edge || clear_req || !armed) begin
      idle_cnt <= 4'h0;
    end else if (tick && idle_cnt != FAIL_TIMEOUT) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end

  // Condition: a set wins over any clear in the same cycle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fail_cond  <= 1'b0;
      fail_start <= 1'b0;
      force_d    <= 1'b0;
    end else begin
      force_d    <= force_fail;
      fail_start <= set_fail && !fail_cond;
      if (set_fail) begin
        fail_cond <= 1'b1;
      end else if (clr_fail) begin
        fail_cond <= 1'b0;
      end
    end
  end

  // Repeat pulse every ten ticks while the condition lasts.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rep_cnt    <= 4'h0;
      repeat_due <= 1'b0;
    end else begin
      repeat_due <= 1'b0;
      if (!fail_cond) begin
        rep_cnt <= 4'h0;
      end else if (tick) begin
        repeat_due <= (rep_cnt == FAIL_REPEAT - 4'h1);
        rep_cnt    <= (rep_cnt == FAIL_REPEAT - 4'h1) ? 4'h0
                                                      : rep_cnt + 4'h1;
      end
    end
  end

  chk_timeout_sets: assert property (@(posedge core_clk) disable iff (!resetn)
    timeout |=> fail_cond)
    else $error("Timeout did not raise the failure condition.");
  chk_repeat_count: assert property (@(posedge core_clk) disable iff (!resetn)
    repeat_due |-> $past(tick) && $past(rep_cnt) == FAIL_REPEAT - 4'h1)
    else $error("Repeat pulse not on the tenth tick.");
endmodule
`default_nettype wire

//--- verilog/csf_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module csf_clock_ctrl (
  // Clock and reset.
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  // Protection key and CPU instruction count.
  input  wire logic                   key_wr,
  input  wire logic [7:0]             key_data,
  input  wire logic                   instr_done,
  // Oscillator control write; index 0 fast, index 1 slow crystal.
  input  wire logic                   osc_ctrl_wr,
  input  wire logic [1:0]             osc_enable_in,
  input  wire logic [1:0]             osc_input_choice_in,
  input  wire logic [1:0]             hf_crystal_startup_delay_in,
  input  wire logic [1:0]             crystal32_startup_delay_in,
  input  wire logic [3:0]             keep_running_in_standby_in,
  input  wire logic                   auto_trim_select_in,
  // Main clock control writes.
  input  wire logic                   main_a_wr,
  input  wire logic [3:0]             main_source_choice_in,
  input  wire logic                   main_clock_pin_output_in,
  input  wire logic                   main_c_wr,
  input  wire logic                   fail_detect_on_in,
  input  wire logic                   fail_detect_force_in,
  input  wire logic [1:0]             fail_detect_target_in,
  input  wire logic                   irq_ctrl_wr,
  input  wire logic                   fail_irq_enable_in,
  input  wire logic                   fail_irq_kind_in,
  input  wire logic                   fail_flag_clear,
  // PLL and trim writes.
  input  wire logic                   pll_wr,
  input  wire logic                   pll_source_in,
  input  wire logic [1:0]             pll_multiplier_in,
  input  wire logic                   tune_wr,
  input  wire logic [7:0]             tune_in,
  input  wire logic [7:0]             auto_trim_value,
  // Oscillator activity and requests.
  input  wire logic [1:0]             osc_level,
  input  wire logic [1:0]             osc_request,
  input  wire logic                   main_clk_level,
  input  wire logic                   low_freq_internal_tick,
  // Power state and fuse.
  input  wire csf_pkg::csf_sleep_type sleep_mode,
  input  wire logic                   periph_main_request,
  input  wire logic                   nvm_busy,
  input  wire logic [3:0]             startup_source_fuse,
  // Oscillator status.
  output logic [1:0]                  osc_pins_dedicated,
  output logic [1:0]                  osc_run,
  output logic [1:0]                  osc_stable,
  // Main clock status.
  output logic                        main_clock_run,
  output logic [3:0]                  main_source_choice,
  output logic                        main_clock_pin_output,
  output logic                        internal_osc_freq_reset,
  // Failure detector status.
  output logic [1:0]                  fail_detect_target,
  output logic                        main_clock_irq_flags,
  output logic                        fail_irq,
  output logic                        fail_nmi,
  // Trim and PLL status.
  output logic [7:0]                  trim_value,
  output logic                        pll_enable,
  output logic                        pll_lock_flag
);
  import csf_pkg::*;

  logic [2:0] ccp_cnt;          // Instructions left in the unlock window.
  logic [1:0] input_choice;     // 1 selects external clock input.
  logic [1:0] hf_sut;           // Fast crystal start-up field.
  logic [1:0] lc_sut;           // Slow crystal start-up field.
  logic [3:0] keep_run;         // Keep-running bit per source code.
  logic       auto_trim_select; // Auto-trim against the slow crystal.
  logic       fail_detect_on;   // Failure detector enable.
  logic       fail_detect_force;// Forced failure test bit.
  logic       fail_irq_enable;  // Failure interrupt enable.
  logic       fail_irq_kind;    // 1 selects non-maskable.
  logic       target_lock;      // Target frozen until reset.
  logic       fuse_taken;       // Fuse source captured after reset.
  logic       main_prev;        // Previous main clock level.
  logic       pll_source;       // 1 selects the external fast source.
  logic [1:0] pll_multiplier;   // Multiplication factor.
  logic [6:0] lock_cnt;         // PLL lock timer.
  logic [1:0] osc_edge;         // Rising edge per crystal oscillator.
  logic       fail_cond;
  logic       fail_start;
  logic       repeat_due;
  wire        unlocked;
  wire        pd_mode;
  wire        awake;
  wire        main_edge;
  wire        main_ready;
  wire        src_edge;
  wire        src_ready;
  wire        src_active;
  wire        armed;
  wire        fallback;
  wire        irq_issue;
  wire        pll_src_ok;
  wire        next_main_run;
  wire [1:0]  sut_sel [2];

  // Decode of protection, power state and detector source.
  assign unlocked   = ccp_cnt != 3'h0;
  assign pd_mode    = sleep_mode == CSF_POWERDOWN;
  assign awake      = sleep_mode == CSF_ACTIVE || sleep_mode == CSF_IDLE;
  assign main_edge  = main_clk_level & ~main_prev;
  assign main_ready = (main_source_choice == SRC_EXT_HF)  ? osc_stable[0] :
                      (main_source_choice == SRC_EXT_LOW) ? osc_stable[1] :
                      1'b1;
  // Target select: 0 main, 1 fast crystal, 2 slow crystal.
  assign src_edge   = (fail_detect_target == TGT_MAIN) ? main_edge
                    : osc_edge[fail_detect_target[1]];
  assign src_ready  = (fail_detect_target == TGT_MAIN) ? main_ready
                    : osc_stable[fail_detect_target[1]];
  assign src_active = (fail_detect_target == TGT_MAIN) ? main_clock_run
                    : osc_run[fail_detect_target[1]];
  assign armed      = fail_detect_on && src_ready
                   && (awake || src_active);
  assign fallback   = fail_start
                   && fail_detect_target == TGT_MAIN;
  assign irq_issue  = fail_irq_enable && (fail_start || repeat_due);
  assign pll_src_ok = pll_source ? osc_stable[0] : 1'b1;
  assign sut_sel[0] = hf_sut;
  assign sut_sel[1] = lc_sut;
  // Main clock runs by power state; keep bit of its source in standby.
  assign next_main_run = awake ? 1'b1
    : (sleep_mode == CSF_STANDBY)
      ? (periph_main_request || keep_run[main_source_choice[1:0]])
      : nvm_busy;

  // Unlock window opens on the key and closes after four instructions.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ccp_cnt <= 3'h0;
    end else if (key_wr && key_data == IO_REGISTER_KEY) begin
      ccp_cnt <= CCP_WINDOW;
    end else if (instr_done && unlocked) begin
      ccp_cnt <= ccp_cnt - 3'h1;
    end
  end

  // Oscillator control register, protected.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      osc_pins_dedicated <= 2'h0;
      input_choice       <= 2'h0;
      hf_sut             <= 2'h0;
      lc_sut             <= 2'h0;
      keep_run           <= 4'h0;
      auto_trim_select   <= 1'b0;
    end else if (osc_ctrl_wr && unlocked) begin
      osc_pins_dedicated <= osc_enable_in;
      input_choice       <= osc_input_choice_in;
      hf_sut             <= hf_crystal_startup_delay_in;
      lc_sut             <= crystal32_startup_delay_in;
      keep_run           <= keep_running_in_standby_in;
      auto_trim_select   <= auto_trim_select_in;
    end
  end

  // Per crystal oscillator: run control and start-up counting.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_osc
      localparam logic [3:0] CODE = (i == 0) ? SRC_EXT_HF : SRC_EXT_LOW;
      wire used;
      wire next_run;
      assign used     = main_clock_run && main_source_choice == CODE;
      assign next_run = osc_pins_dedicated[i] && (osc_request[i] || used
                     || (keep_run[CODE[1:0]] && !pd_mode));
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          osc_run[i] <= 1'b0;
        end else begin
          osc_run[i] <= next_run;
        end
      end
      csf_startup u_sut (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .run       (osc_run[i]),
        .ext_clock (input_choice[i]),
        .delay_sel (sut_sel[i]),
        .osc_level (osc_level[i]),
        .stable    (osc_stable[i]),
        .osc_edge  (osc_edge[i])
      );
    end
  endgenerate

  // Failure detector core.
  csf_fail_detect u_cfd (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .armed      (armed),
    .src_edge   (src_edge),
    .tick       (low_freq_internal_tick),
    .force_fail (fail_detect_force),
    .clear_req  (fail_flag_clear),
    .fail_cond  (fail_cond),
    .fail_start (fail_start),
    .repeat_due (repeat_due)
  );

  // Main clock control A: source and pin output, with fallback.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      main_source_choice      <= SRC_INT_HF;
      main_clock_pin_output   <= 1'b0;
      fuse_taken              <= 1'b0;
      internal_osc_freq_reset <= 1'b0;
    end else begin
      fuse_taken              <= 1'b1;
      internal_osc_freq_reset <= fallback;
      if (!fuse_taken) begin
        // Start-up source comes from the fuse after reset release.
        main_source_choice <= startup_source_fuse;
      end else if (fallback) begin
        main_source_choice    <= startup_source_fuse;
        main_clock_pin_output <= 1'b0;
      end else if (main_a_wr && unlocked) begin
        main_source_choice    <= main_source_choice_in;
        main_clock_pin_output <= main_clock_pin_output_in;
      end
    end
  end

  // Main clock control C and interrupt control, both protected.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fail_detect_on     <= 1'b0;
      fail_detect_force  <= 1'b0;
      fail_detect_target <= TGT_MAIN;
      fail_irq_enable    <= 1'b0;
      fail_irq_kind      <= 1'b0;
      target_lock        <= 1'b0;
    end else begin
      if (fail_detect_on && fail_irq_enable && fail_irq_kind) begin
        target_lock <= 1'b1;
      end
      if (main_c_wr && unlocked) begin
        fail_detect_on    <= fail_detect_on_in;
        fail_detect_force <= fail_detect_force_in;
        if (!target_lock) begin
          fail_detect_target <= fail_detect_target_in;
        end
      end
      if (irq_ctrl_wr && unlocked) begin
        fail_irq_enable <= fail_irq_enable_in;
        fail_irq_kind   <= fail_irq_kind_in;
      end
    end
  end

  // Failure flag and interrupt outputs; set wins over clear.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      main_clock_irq_flags <= 1'b0;
      fail_irq             <= 1'b0;
      fail_nmi             <= 1'b0;
      main_prev            <= 1'b0;
      main_clock_run       <= 1'b1;
    end else begin
      main_prev      <= main_clk_level;
      main_clock_run <= next_main_run;
      fail_irq       <= irq_issue && !fail_irq_kind;
      fail_nmi       <= irq_issue && fail_irq_kind;
      if (fail_start) begin
        main_clock_irq_flags <= 1'b1;
      end else if (fail_flag_clear) begin
        main_clock_irq_flags <= 1'b0;
      end
    end
  end

  // Trim register: manual writes only without auto-trim.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      trim_value <= TRIM_RESET;
    end else if (auto_trim_select) begin
      trim_value <= auto_trim_value;
    end else if (tune_wr) begin
      trim_value <= tune_in;
    end
  end

  // PLL: a nonzero multiplier enables it; lock after the lock time.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pll_source     <= 1'b0;
      pll_multiplier <= 2'h0;
      pll_enable     <= 1'b0;
      lock_cnt       <= 7'h00;
      pll_lock_flag  <= 1'b0;
    end else if (pll_wr && unlocked) begin
      pll_source     <= pll_source_in;
      pll_multiplier <= pll_multiplier_in;
      pll_enable     <= pll_multiplier_in != 2'h0;
      lock_cnt       <= 7'h00;
      pll_lock_flag  <= 1'b0;
    end else if (!pll_enable || !pll_src_ok) begin
      lock_cnt      <= 7'h00;
      pll_lock_flag <= 1'b0;
    end else if (!pll_lock_flag) begin
      lock_cnt      <= lock_cnt + 7'h01;
      pll_lock_flag <= lock_cnt == PLL_LOCK_CYCLES - 7'h01;
    end
  end

  chk_ccp_blocked: assert property (@(posedge core_clk) disable iff (!resetn)
    fuse_taken && main_a_wr && !unlocked && !fallback
    |=> $stable(main_source_choice))
    else $error("Protected write took effect without the key.");
  chk_fallback_source: assert property (@(posedge core_clk)
    disable iff (!resetn) fuse_taken && fallback
    |=> main_source_choice == $past(startup_source_fuse)
        && !main_clock_pin_output)
    else $error("Fallback did not restore the start-up source.");
  chk_irq_issue: assert property (@(posedge core_clk) disable iff (!resetn)
    fail_start && fail_irq_enable |=> fail_irq != fail_nmi
    ##0 main_clock_irq_flags)
    else $error("Failure did not raise flag and one interrupt.");
  chk_run_enable: assert property (@(posedge core_clk) disable iff (!resetn)
    !osc_pins_dedicated[0] |=> !osc_run[0])
    else $error("Disabled oscillator is running.");
  chk_trim_locked: assert property (@(posedge core_clk) disable iff (!resetn)
    auto_trim_select && tune_wr |=> trim_value == $past(auto_trim_value))
    else $error("Manual trim write accepted during auto-trim.");
  chk_target_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    target_lock |=> $stable(fail_detect_target) && target_lock)
    else $error("Locked failure target changed.");
  chk_pll_lock: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(pll_lock_flag) |-> pll_enable && lock_cnt == PLL_LOCK_CYCLES)
    else $error("PLL lock flag raised early.");
endmodule
`default_nettype wire

//--- bench/csf_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the oscillators and the main clock seen by the block.
module csf_osc_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] osc_run,
  input  wire logic       halt,
  output var  logic [1:0] osc_level = 2'h0,
  output var  logic       main_clk_level = 1'b0
);
  logic ph = 1'b0;
  // A stopped or halted oscillator output rests low, never at its old level.
  // The external clock runs at a quarter of the core rate, below 32 MHz.
  always @(negedge core_clk) begin
    ph <= ~ph;
    main_clk_level <= halt ? 1'b0 : ~main_clk_level;
    for (int i = 0; i < 2; i++)
      osc_level[i] <= (osc_run[i] & ~halt) ? osc_level[i] ^ ph : 1'b0;
  end
endmodule
`default_nettype wire

//--- bench/csf_clock_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csf_clock_ctrl_tb;
  import csf_pkg::*;
  logic core_clk = 0, resetn = 0, key_wr = 0, instr_done = 0, halt = 0;
  logic osc_ctrl_wr = 0, auto_trim_select_in = 0, main_a_wr = 0, pll_wr = 0;
  logic main_clock_pin_output_in = 0, main_c_wr = 0, fail_detect_on_in = 0;
  logic fail_detect_force_in = 0, irq_ctrl_wr = 0, fail_irq_enable_in = 0;
  logic fail_irq_kind_in = 0, fail_flag_clear = 0, tune_wr = 0;
  logic pll_source_in = 0, periph_main_request = 0, nvm_busy = 0;
  logic low_freq_internal_tick = 0, main_clk_level, main_clock_run;
  logic main_clock_pin_output, internal_osc_freq_reset, main_clock_irq_flags;
  logic fail_irq, fail_nmi, pll_enable, pll_lock_flag;
  logic [1:0] osc_enable_in = 0, osc_input_choice_in = 0, osc_request = 0;
  logic [1:0] hf_crystal_startup_delay_in = 0, crystal32_startup_delay_in = 0;
  logic [1:0] fail_detect_target_in = 0, pll_multiplier_in = 0, osc_level;
  logic [1:0] osc_pins_dedicated, osc_run, osc_stable, fail_detect_target;
  logic [3:0] keep_running_in_standby_in = 0, main_source_choice_in = 0;
  logic [3:0] startup_source_fuse = SRC_INT_LOW, main_source_choice, tk = 0;
  logic [7:0] key_data = 0, tune_in = 0, auto_trim_value = 0, trim_value;
  csf_sleep_type sleep_mode = CSF_ACTIVE;
  int err_total = 0, n_compared = 0, n_irq = 0, n;
  // Rows: key used, pin bit, source; then expected pin bit and source.
  logic [19:0] rows [4] = '{20'h1_1_3_1_3, 20'h0_0_2_1_3,
                            20'h1_0_2_0_2, 20'h1_1_0_1_0};
  csf_clock_ctrl u_csf_clock_ctrl (.*);
  csf_osc_model u_csf_osc_model (.*);
  always #5 core_clk = ~core_clk;
  // Slow internal tick every eight cycles; interrupt pulses are counted.
  always @(negedge core_clk) begin
    tk <= tk + 4'h1;
    low_freq_internal_tick <= tk[2:0] == 3'h0;
    if (fail_irq === 1'b1) n_irq++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic key;
    key_wr = 1;
    key_data = IO_REGISTER_KEY;
    cyc(1);
    key_wr = 0;
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo;
    if (n < 200) return;
    err_total++;
    conclude();
  endtask
  initial begin
    osc_request = 2'h3;
    cyc(10);
    chk(main_clock_run, 1);
    chk(main_source_choice, SRC_INT_HF);
    resetn = 1;
    cyc(3);
    chk(main_source_choice, SRC_INT_LOW);
    chk(osc_run, 0);
    $display("reset test done");
    // Each keyed row closes the window with four retired instructions.
    foreach (rows[i]) begin
      if (rows[i][16]) key();
      main_source_choice_in = rows[i][11:8];
      main_clock_pin_output_in = rows[i][12];
      main_a_wr = 1;
      cyc(1);
      main_a_wr = 0;
      instr_done = 1;
      cyc(4);
      instr_done = 0;
      chk(main_source_choice, rows[i][3:0]);
      chk(main_clock_pin_output, rows[i][4]);
    end
    key();
    osc_enable_in = 2'h1;
    osc_input_choice_in = 2'h1;
    osc_ctrl_wr = 1;
    cyc(1);
    osc_ctrl_wr = 0;
    for (n = 0; n < 200 && osc_stable[0] !== 1'b1; n++) cyc(1);
    tmo();
    chk(n < 9 && n > 3, 1);
    chk(osc_pins_dedicated, 2'h1);
    chk(osc_run, 2'h1);
    $display("oscillator test done");
    key();
    fail_detect_on_in = 1;
    fail_detect_target_in = TGT_EXT_HF;
    fail_irq_enable_in = 1;
    main_c_wr = 1;
    irq_ctrl_wr = 1;
    cyc(1);
    main_c_wr = 0;
    irq_ctrl_wr = 0;
    halt = 1;
    for (n = 0; n < 200 && main_clock_irq_flags !== 1'b1; n++) cyc(1);
    tmo();
    chk(n > 20 && n < 48, 1);
    cyc(120);
    chk(n_irq, 2);
    chk(main_source_choice, SRC_INT_HF);
    halt = 0;
    fail_flag_clear = 1;
    cyc(1);
    fail_flag_clear = 0;
    cyc(3);
    chk(main_clock_irq_flags, 0);
    key();
    fail_detect_target_in = TGT_MAIN;
    fail_detect_force_in = 1;
    main_c_wr = 1;
    cyc(1);
    main_c_wr = 0;
    for (n = 0; n < 200 && main_source_choice !== SRC_INT_LOW; n++) cyc(1);
    tmo();
    chk(internal_osc_freq_reset, 1);
    chk(fail_detect_target, TGT_MAIN);
    chk(main_clock_pin_output, 0);
    $display("failure test done");
    key();
    pll_multiplier_in = 2'h1;
    pll_wr = 1;
    cyc(1);
    pll_wr = 0;
    cyc(1);
    chk(pll_enable, 1);
    for (n = 0; n < 200 && pll_lock_flag !== 1'b1; n++) cyc(1);
    tmo();
    chk(n > 50, 1);
    tune_in = 8'h3C;
    tune_wr = 1;
    cyc(1);
    tune_wr = 0;
    cyc(1);
    chk(trim_value, 8'h3C);
    // Auto-trim takes over the register and locks out manual writes.
    key();
    auto_trim_select_in = 1;
    auto_trim_value = 8'hA5;
    osc_ctrl_wr = 1;
    cyc(1);
    osc_ctrl_wr = 0;
    tune_in = 8'h11;
    tune_wr = 1;
    cyc(1);
    tune_wr = 0;
    cyc(1);
    chk(trim_value, 8'hA5);
    auto_trim_select_in = 0;
    osc_ctrl_wr = 1;
    cyc(1);
    osc_ctrl_wr = 0;
    auto_trim_value = 8'h00;
    cyc(2);
    chk(trim_value, 8'hA5);
    // Non-maskable kind locks the target; repeats come out as NMI.
    key();
    fail_irq_kind_in = 1;
    irq_ctrl_wr = 1;
    cyc(1);
    irq_ctrl_wr = 0;
    cyc(1);
    fail_detect_target_in = TGT_EXT_LOW;
    main_c_wr = 1;
    cyc(1);
    main_c_wr = 0;
    cyc(1);
    chk(fail_detect_target, TGT_MAIN);
    for (n = 0; n < 200 && fail_nmi !== 1'b1; n++) cyc(1);
    tmo();
    chk(fail_irq, 0);
    chk(fail_nmi, 1);
    // Main clock run by power state.
    sleep_mode = CSF_STANDBY;
    cyc(2);
    chk(main_clock_run, 0);
    periph_main_request = 1;
    cyc(2);
    chk(main_clock_run, 1);
    sleep_mode = CSF_POWERDOWN;
    periph_main_request = 0;
    nvm_busy = 1;
    cyc(2);
    chk(main_clock_run, 1);
    nvm_busy = 0;
    cyc(2);
    chk(main_clock_run, 0);
    sleep_mode = CSF_ACTIVE;
    $display("trim, lock and sleep test done");
    resetn = 0;
    cyc(2);
    chk(main_clock_irq_flags, 0);
    $display("pll and reset test done");
    conclude();
  end
endmodule
`default_nettype wire
